// ==== shared/csc_pkg.sv ====
// Package: states, zones, register map, scaling codes and carrier structs for the charge controller
package csc_pkg;

	// ---------------------------------------------------------------
	// Register map (byte addresses)
	// ---------------------------------------------------------------
	localparam logic [7:0] CSC_ADDR_CTRL   = 8'h00;
	localparam logic [7:0] CSC_ADDR_STATUS = 8'h04;
	localparam logic [7:0] CSC_ADDR_DRIVE  = 8'h08;
	localparam logic [7:0] CSC_ADDR_FLAGS  = 8'h0c;

	// CTRL fields
	localparam int CSC_CTRL_SOLAR_BIT = 0;
	localparam int CSC_CTRL_CLR_BIT   = 1;
	localparam logic [31:0] CSC_CTRL_RESET = 32'h0000_0000;

	// ---------------------------------------------------------------
	// Scaling codes (current in thousandths of nominal)
	// ---------------------------------------------------------------
	localparam logic [9:0] CSC_I_FULL    = 10'h3e8; // 1000 permille
	localparam logic [9:0] CSC_I_HALF    = 10'h1f4; // 500 permille
	localparam logic [9:0] CSC_I_QUARTER = 10'h0fa; // 250 permille
	localparam logic [9:0] CSC_I_NONE    = 10'h000;
	// Regulation target in hundredths of a percent of nominal
	localparam logic [13:0] CSC_V_NOMINAL = 14'h2710; // 100.00 %
	localparam logic [13:0] CSC_V_REDUCED = 14'h263f; // 97.91 %

	// Sync depth for comparator inputs
	localparam int CSC_SYNC_STAGES = 3;
	localparam int CSC_N_CMP       = 16;
	// Edges the switches must run before the current flag is trusted
	localparam int CSC_TERM_SETTLE = 8;

	typedef enum {
		CSC_SLEEP,
		CSC_TRICKLE,
		CSC_CC,
		CSC_CV,
		CSC_DONE_ST,
		CSC_OVP,
		CSC_SUSPEND
	} csc_state_type;

	typedef enum logic [2:0] {
		CSC_Z_HOT    = 3'h0,
		CSC_Z_WARM   = 3'h1,
		CSC_Z_NORMAL = 3'h2,
		CSC_Z_COOL   = 3'h3,
		CSC_Z_COLD   = 3'h4
	} csc_zone_type;

	// Comparator flags from the analog front end, all active high
	typedef struct packed {
		logic uvlo_ok;              // Input above undervoltage level
		logic vin_gt_bat;           // Input exceeds battery by sleep_release_margin
		logic vbat_gt_trickle;      // Battery above 66.6 % of target
		logic vbat_near_reg;        // Battery reached target, constant-voltage mode
		logic i_below_term;         // Current below 15 % of full_scale_current
		logic vbat_gt_recharge;     // Battery above 95.8 % of target
		logic vbat_ovp;             // Battery above target by 6.8 %
		logic ovp_release;          // Overvoltage cleared
		logic temp_lt_hot;          // hot_entry_threshold crossed
		logic temp_gt_hot_rel;      // hot_release_threshold crossed
		logic temp_lt_warm;         // warm_entry_threshold crossed
		logic temp_gt_warm_rel;     // warm_release_threshold crossed
		logic temp_gt_cool;         // cool_entry_threshold crossed
		logic temp_lt_cool_rel;     // cool_release_threshold crossed
		logic temp_gt_cold;         // cold_entry_threshold crossed
		logic temp_lt_cold_rel;     // cold_release_threshold crossed
	} csc_cmp_type;

	// Outputs toward pins and the analog loops
	typedef struct packed {
		logic        high_side_en;
		logic        low_side_en;
		logic        charging_ind_oe;
		logic        done_ind_oe;
		logic        reverse_block_gate;   // 1: pulled to battery, blocker off
		logic [9:0]  current_scale;
		logic [13:0] regulation_target_voltage;
	} csc_drive_type;

endpackage

// ==== design/csc_sync.sv ====
// Three-stage synchroniser with agreement filter for a vector of comparator flags
`timescale 1ns/1ps

module csc_sync #(
	parameter int WIDTH = 16
) (
	input  wire logic             pclk,
	input  wire logic             presetn,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] meta_ff;
	logic [WIDTH-1:0] s2_ff;
	logic [WIDTH-1:0] s3_ff;

	// First stage feeds only the second
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_ff <= '0;
			s2_ff   <= '0;
			s3_ff   <= '0;
		end else begin
			meta_ff <= async_in;
			s2_ff   <= meta_ff;
			s3_ff   <= s2_ff;
		end
	end

	// A change is accepted only when stages two and three agree
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync_out <= '0;
		end else begin
			for (int i = 0; i < WIDTH; i++) begin
				if (s2_ff[i] == s3_ff[i]) begin
					sync_out[i] <= s3_ff[i];
				end
			end
		end
	end

endmodule // csc_sync

// ==== design/csc_charge_ctrl.sv ====
// Charge-mode state machine, temperature zoning, indicators and APB registers
//
// Contract
// - CV mode: terminate at 15 percent current
// - Terminated: both power transistors off
// - Terminated: charging released, completion pulled low
// - Solar mode: terminate needs voltage and current
// - Done: recharge below 95.8 percent target
// - Five hysteretic temperature zones from comparators
// - Normal zone: full current, nominal voltage
// - Cool zone: quarter current, nominal voltage
// - Warm zone: half current, reduced voltage
// - Hot/cold: suspend, both indicators released
// - Resume automatically once hot/cold left
// - Charging indicator low only while charging
// - UVLO, low input, hot/cold release both
// - No input: sleep, gate to battery
// - Outside sleep the blocking gate stays low
// - No battery: cycle done/charge, completion pulses
// - Below trickle fraction: quarter current charge
// - Overvoltage: both transistors off until cleared
// - Start only with UVLO ok and margin
`timescale 1ns/1ps

module csc_charge_ctrl (
	input  wire logic                   pclk,
	input  wire logic                   presetn,
	input  wire logic                   psel,
	input  wire logic                   penable,
	input  wire logic                   pwrite,
	input  wire logic [7:0]             paddr,
	input  wire logic [31:0]            pwdata,
	output logic      [31:0]            prdata,
	output logic                        pready,
	output logic                        pslverr,
	input  wire csc_pkg::csc_cmp_type   cmp_async,
	input  wire logic                   solar_tracking_mode,
	output csc_pkg::csc_drive_type      drive,
	output logic                        charging_indicator_n_o,
	output logic                        charging_indicator_n_oe,
	output logic                        done_indicator_n_o,
	output logic                        done_indicator_n_oe
);

	csc_pkg::csc_cmp_type  cmp;
	csc_pkg::csc_state_type state_ff;
	csc_pkg::csc_state_type nxt_state;
	csc_pkg::csc_zone_type zone_ff;
	csc_pkg::csc_zone_type nxt_zone;
	logic [31:0]           ctrl_ff;
	logic [7:0]            done_cnt_ff;
	logic                  solar_ff;
	logic                  solar_pin_sync;
	logic [3:0]            settle_ff;
	logic                  term_ok;
	logic                  input_ok;
	logic                  temp_block;
	logic                  charging;
	logic                  apb_go;

	// ---------------------------------------------------------------
	// Input synchronisation
	// ---------------------------------------------------------------
	csc_sync #(
		.WIDTH (csc_pkg::CSC_N_CMP)
	) u_sync (
		.pclk     (pclk),
		.presetn  (presetn),
		.async_in (cmp_async),
		.sync_out (cmp)
	);

	// Solar pin is asynchronous like the comparators, so it gets the same filter
	csc_sync #(
		.WIDTH (1)
	) u_solar_sync (
		.pclk     (pclk),
		.presetn  (presetn),
		.async_in (solar_tracking_mode),
		.sync_out (solar_pin_sync)
	);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			solar_ff <= 1'b0;
		end else begin
			solar_ff <= solar_pin_sync | ctrl_ff[csc_pkg::CSC_CTRL_SOLAR_BIT];
		end
	end

	// ---------------------------------------------------------------
	// Temperature zone with hysteresis
	// ---------------------------------------------------------------
	always_comb begin
		nxt_zone = zone_ff;
		case (zone_ff)
			csc_pkg::CSC_Z_HOT: begin
				if (cmp.temp_gt_hot_rel) nxt_zone = csc_pkg::CSC_Z_WARM;
			end
			csc_pkg::CSC_Z_WARM: begin
				if (cmp.temp_lt_hot) nxt_zone = csc_pkg::CSC_Z_HOT;
				else if (cmp.temp_gt_warm_rel) nxt_zone = csc_pkg::CSC_Z_NORMAL;
			end
			csc_pkg::CSC_Z_NORMAL: begin
				if (cmp.temp_lt_warm) nxt_zone = csc_pkg::CSC_Z_WARM;
				else if (cmp.temp_gt_cool) nxt_zone = csc_pkg::CSC_Z_COOL;
			end
			csc_pkg::CSC_Z_COOL: begin
				if (cmp.temp_gt_cold) nxt_zone = csc_pkg::CSC_Z_COLD;
				else if (cmp.temp_lt_cool_rel) nxt_zone = csc_pkg::CSC_Z_NORMAL;
			end
			csc_pkg::CSC_Z_COLD: begin
				if (cmp.temp_lt_cold_rel) nxt_zone = csc_pkg::CSC_Z_COOL;
			end
			default: nxt_zone = csc_pkg::CSC_Z_NORMAL;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			zone_ff <= csc_pkg::CSC_Z_NORMAL;
		end else begin
			zone_ff <= nxt_zone;
		end
	end

	// ---------------------------------------------------------------
	// Charge state machine
	// ---------------------------------------------------------------
	assign input_ok   = cmp.uvlo_ok & cmp.vin_gt_bat;
	assign temp_block = (zone_ff == csc_pkg::CSC_Z_HOT) ||
	                    (zone_ff == csc_pkg::CSC_Z_COLD);
	// Solar mode also demands the recharge-level voltage
	assign term_ok    = cmp.i_below_term & (settle_ff == 4'(csc_pkg::CSC_TERM_SETTLE)) &
	                    (~solar_ff | cmp.vbat_gt_recharge);

	// With the switches off the current flag reads low; trusting it on re-entry to
	// constant voltage would terminate at once, so wait until the flag has caught up
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			settle_ff <= 4'h0;
		end else if (!drive.high_side_en) begin
			settle_ff <= 4'h0;
		end else if (settle_ff != 4'(csc_pkg::CSC_TERM_SETTLE)) begin
			settle_ff <= settle_ff + 4'h1;
		end
	end

	function automatic csc_pkg::csc_state_type entry_mode(input logic above_trickle);
		entry_mode = above_trickle ? csc_pkg::CSC_CC : csc_pkg::CSC_TRICKLE;
	endfunction

	always_comb begin
		nxt_state = state_ff;
		if (!input_ok) begin
			nxt_state = csc_pkg::CSC_SLEEP;
		end else if (temp_block) begin
			nxt_state = csc_pkg::CSC_SUSPEND;
		end else if (cmp.vbat_ovp && state_ff != csc_pkg::CSC_SLEEP) begin
			nxt_state = csc_pkg::CSC_OVP;
		end else begin
			case (state_ff)
				csc_pkg::CSC_SLEEP: begin
					nxt_state = entry_mode(cmp.vbat_gt_trickle);
				end
				csc_pkg::CSC_SUSPEND: begin
					nxt_state = entry_mode(cmp.vbat_gt_trickle);
				end
				csc_pkg::CSC_TRICKLE: begin
					if (cmp.vbat_gt_trickle) nxt_state = csc_pkg::CSC_CC;
				end
				csc_pkg::CSC_CC: begin
					if (cmp.vbat_near_reg) nxt_state = csc_pkg::CSC_CV;
				end
				csc_pkg::CSC_CV: begin
					if (term_ok) nxt_state = csc_pkg::CSC_DONE_ST;
				end
				csc_pkg::CSC_DONE_ST: begin
					if (!cmp.vbat_gt_recharge) nxt_state = csc_pkg::CSC_CV;
				end
				csc_pkg::CSC_OVP: begin
					if (cmp.ovp_release) nxt_state = csc_pkg::CSC_CV;
				end
				default: nxt_state = csc_pkg::CSC_SLEEP;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_ff <= csc_pkg::CSC_SLEEP;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// Counts completions; with no battery it climbs as the output ripples
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			done_cnt_ff <= 8'h00;
		end else if (pwrite && apb_go && paddr == csc_pkg::CSC_ADDR_CTRL &&
		             pwdata[csc_pkg::CSC_CTRL_CLR_BIT]) begin
			// Set wins over the clear
			done_cnt_ff <= (nxt_state == csc_pkg::CSC_DONE_ST &&
			                state_ff != csc_pkg::CSC_DONE_ST) ? 8'h01 : 8'h00;
		end else if (nxt_state == csc_pkg::CSC_DONE_ST && state_ff != csc_pkg::CSC_DONE_ST) begin
			done_cnt_ff <= done_cnt_ff + 8'h01;
		end
	end

	// ---------------------------------------------------------------
	// Outputs
	// ---------------------------------------------------------------
	assign charging = (state_ff == csc_pkg::CSC_TRICKLE) ||
	                  (state_ff == csc_pkg::CSC_CC) ||
	                  (state_ff == csc_pkg::CSC_CV);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			drive <= '0;
			drive.reverse_block_gate <= 1'b1;
		end else begin
			drive.high_side_en <= charging & (nxt_state == state_ff);
			drive.low_side_en  <= charging & (nxt_state == state_ff);
			drive.charging_ind_oe <= charging;
			drive.done_ind_oe  <= (state_ff == csc_pkg::CSC_DONE_ST);
			drive.reverse_block_gate <= (state_ff == csc_pkg::CSC_SLEEP);
			if (!charging) begin
				drive.current_scale <= csc_pkg::CSC_I_NONE;
			end else if (state_ff == csc_pkg::CSC_TRICKLE ||
			             zone_ff == csc_pkg::CSC_Z_COOL) begin
				drive.current_scale <= csc_pkg::CSC_I_QUARTER;
			end else if (zone_ff == csc_pkg::CSC_Z_WARM) begin
				drive.current_scale <= csc_pkg::CSC_I_HALF;
			end else begin
				drive.current_scale <= csc_pkg::CSC_I_FULL;
			end
			drive.regulation_target_voltage <= (zone_ff == csc_pkg::CSC_Z_WARM) ?
				csc_pkg::CSC_V_REDUCED : csc_pkg::CSC_V_NOMINAL;
		end
	end

	// Open drain: pin only ever pulled low
	assign charging_indicator_n_o  = 1'b0;
	assign charging_indicator_n_oe = drive.charging_ind_oe;
	assign done_indicator_n_o      = 1'b0;
	assign done_indicator_n_oe     = drive.done_ind_oe;

	// ---------------------------------------------------------------
	// APB slave, zero wait states
	// ---------------------------------------------------------------
	assign apb_go  = psel & penable;
	assign pready  = 1'b1;
	assign pslverr = apb_go && !(paddr == csc_pkg::CSC_ADDR_CTRL ||
	                             paddr == csc_pkg::CSC_ADDR_STATUS ||
	                             paddr == csc_pkg::CSC_ADDR_DRIVE ||
	                             paddr == csc_pkg::CSC_ADDR_FLAGS);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_ff <= csc_pkg::CSC_CTRL_RESET;
		end else if (apb_go && pwrite && paddr == csc_pkg::CSC_ADDR_CTRL) begin
			// Clear bit is self-clearing; only the solar bit is stored
			ctrl_ff <= {31'h0000_0000, pwdata[csc_pkg::CSC_CTRL_SOLAR_BIT]};
		end
	end

	always_comb begin
		prdata = 32'h0000_0000;
		case (paddr)
			csc_pkg::CSC_ADDR_CTRL:   prdata = ctrl_ff;
			csc_pkg::CSC_ADDR_STATUS: prdata = {18'h00000, done_cnt_ff, 3'(zone_ff),
			                                    3'(state_ff)};
			csc_pkg::CSC_ADDR_DRIVE:  prdata = {3'h0, drive};
			csc_pkg::CSC_ADDR_FLAGS:  prdata = {16'h0000, cmp};
			default:                  prdata = 32'h0000_0000;
		endcase
	end

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	sequence s_cv_term;
		state_ff == csc_pkg::CSC_CV && input_ok && !temp_block && !cmp.vbat_ovp && term_ok;
	endsequence

	sequence s_done_seen;
		##1 state_ff == csc_pkg::CSC_DONE_ST ##1 !drive.high_side_en && drive.done_ind_oe;
	endsequence

	AST_TERMINATE: assert property (@(posedge pclk) disable iff (!presetn)
		s_cv_term |-> s_done_seen) else $error("CV did not terminate");

	AST_SOLAR_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
		(state_ff == csc_pkg::CSC_CV && solar_ff && !cmp.vbat_gt_recharge)
		|=> state_ff != csc_pkg::CSC_DONE_ST) else $error("Solar termination too early");

	AST_DONE_OFF: assert property (@(posedge pclk) disable iff (!presetn)
		state_ff == csc_pkg::CSC_DONE_ST |=> !drive.high_side_en && !drive.low_side_en)
		else $error("Switches on while terminated");

	AST_DONE_IND: assert property (@(posedge pclk) disable iff (!presetn)
		state_ff == csc_pkg::CSC_DONE_ST |=> done_indicator_n_oe && !charging_indicator_n_oe)
		else $error("Wrong indicators in termination");

	AST_RECHARGE: assert property (@(posedge pclk) disable iff (!presetn)
		(state_ff == csc_pkg::CSC_DONE_ST && input_ok && !temp_block && !cmp.vbat_ovp &&
		 !cmp.vbat_gt_recharge) |=> state_ff == csc_pkg::CSC_CV)
		else $error("No recharge");

	AST_SUSPEND: assert property (@(posedge pclk) disable iff (!presetn)
		(input_ok && temp_block) |=> ##1 !charging_indicator_n_oe && !done_indicator_n_oe)
		else $error("Indicators driven in hot or cold");

	AST_WARM: assert property (@(posedge pclk) disable iff (!presetn)
		(charging && state_ff == csc_pkg::CSC_CV && zone_ff == csc_pkg::CSC_Z_WARM)
		|=> drive.current_scale == csc_pkg::CSC_I_HALF &&
		    drive.regulation_target_voltage == csc_pkg::CSC_V_REDUCED)
		else $error("Warm scaling wrong");

	AST_SLEEP_GATE: assert property (@(posedge pclk) disable iff (!presetn)
		!input_ok |=> ##1 drive.reverse_block_gate && !charging_indicator_n_oe)
		else $error("Sleep gate not raised");

endmodule // csc_charge_ctrl

// ==== tb/csc_far_side.sv ====
// Behavioural battery, thermistor and input source feeding the comparator flags
`timescale 1ns/1ps

module csc_far_side #(
	parameter logic [15:0] NEAR_REG = 16'h26ac, // Hundredths of a percent of target
	parameter logic [15:0] OVP_REL  = 16'h283c  // Hundredths of a percent of target
) (
	input  wire logic                   vin_ok,
	input  wire logic                   vin_above,
	input  wire logic [15:0]            vbat,
	input  wire logic [9:0]             cur_lim,
	input  wire logic [11:0]            temp_mv,
	input  wire csc_pkg::csc_drive_type drive,
	output csc_pkg::csc_cmp_type        cmp
);
	logic [9:0] i_bat;

	// Current flows only while the high side runs; the load may cap it below the set scale
	assign i_bat = !drive.high_side_en ? 10'h000 :
		(drive.current_scale < cur_lim ? drive.current_scale : cur_lim);

	// ---------------------------------------------------------------
	// Comparators: voltages in hundredths of a percent, current in permille
	// ---------------------------------------------------------------
	always_comb begin
		cmp.uvlo_ok          = vin_ok;
		cmp.vin_gt_bat       = vin_above;
		cmp.vbat_gt_trickle  = vbat > 16'h1a04;
		cmp.vbat_near_reg    = vbat >= NEAR_REG;
		cmp.i_below_term     = i_bat < 10'h096;
		cmp.vbat_gt_recharge = vbat > 16'h256c;
		cmp.vbat_ovp         = vbat > 16'h29b8;
		cmp.ovp_release      = vbat < OVP_REL;
		cmp.temp_lt_hot      = temp_mv < 12'h064;
		cmp.temp_gt_hot_rel  = temp_mv > 12'h078;
		cmp.temp_lt_warm     = temp_mv < 12'h087;
		cmp.temp_gt_warm_rel = temp_mv > 12'h09b;
		cmp.temp_gt_cool     = temp_mv > 12'h226;
		cmp.temp_lt_cool_rel = temp_mv < 12'h1f9;
		cmp.temp_gt_cold     = temp_mv > 12'h352;
		cmp.temp_lt_cold_rel = temp_mv < 12'h325;
	end
endmodule // csc_far_side

// ==== tb/test_charge_state_controller.sv ====
// Self-checking bench for the charge state controller
`timescale 1ns/1ps

module test_charge_state_controller;
	typedef struct packed {
		logic [11:0] mv;
		logic [15:0] vb;
		logic [2:0]  z;
		logic [2:0]  s;
		logic [9:0]  i;
		logic [13:0] v;
	} csc_tc_type;

	logic                   pclk = 1'b0;
	logic                   presetn = 1'b0;
	logic                   psel = 1'b0;
	logic                   penable = 1'b0;
	logic                   pwrite = 1'b0;
	logic [7:0]             paddr = 8'h00;
	logic [31:0]            pwdata = 32'h0000_0000;
	logic [31:0]            prdata;
	logic                   pready;
	logic                   pslverr;
	csc_pkg::csc_cmp_type   cmp_async;
	logic                   solar_tracking_mode = 1'b0;
	csc_pkg::csc_drive_type drive;
	logic                   chg_o;
	logic                   chg_oe;
	logic                   done_o;
	logic                   done_oe;
	logic                   vin_ok = 1'b0;
	logic                   vin_above = 1'b0;
	logic [15:0]            vbat = 16'h1388;
	logic [9:0]             cur_lim = 10'h3e8;
	logic [11:0]            temp_mv = 12'h12c;
	logic [31:0]            rd;
	logic                   err;
	int                     n_fail = 0;
	int                     num_checks = 0;
	int                     cycles = 0;
	// Zone walk: entry, hysteresis band, release; states 1 trickle 2 cc 6 suspend
	csc_tc_type             tcs [14] = '{
		'{12'h12c, 16'h1f40, 3'h2, 3'h2, 10'h3e8, 14'h2710},
		'{12'h258, 16'h1f40, 3'h3, 3'h2, 10'h0fa, 14'h2710},
		'{12'h212, 16'h1f40, 3'h3, 3'h2, 10'h0fa, 14'h2710},
		'{12'h1e0, 16'h1f40, 3'h2, 3'h2, 10'h3e8, 14'h2710},
		'{12'h384, 16'h1f40, 3'h4, 3'h6, 10'h000, 14'h0000},
		'{12'h33e, 16'h1f40, 3'h4, 3'h6, 10'h000, 14'h0000},
		'{12'h2bc, 16'h1388, 3'h3, 3'h1, 10'h0fa, 14'h2710},
		'{12'h12c, 16'h1f40, 3'h2, 3'h2, 10'h3e8, 14'h2710},
		'{12'h082, 16'h1f40, 3'h1, 3'h2, 10'h1f4, 14'h263f},
		'{12'h091, 16'h1f40, 3'h1, 3'h2, 10'h1f4, 14'h263f},
		'{12'h0a0, 16'h1f40, 3'h2, 3'h2, 10'h3e8, 14'h2710},
		'{12'h05a, 16'h1f40, 3'h0, 3'h6, 10'h000, 14'h0000},
		'{12'h06e, 16'h1f40, 3'h0, 3'h6, 10'h000, 14'h0000},
		'{12'h07d, 16'h1f40, 3'h1, 3'h2, 10'h1f4, 14'h263f}};

	csc_charge_ctrl dut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.cmp_async(cmp_async), .solar_tracking_mode(solar_tracking_mode), .drive(drive),
		.charging_indicator_n_o(chg_o), .charging_indicator_n_oe(chg_oe),
		.done_indicator_n_o(done_o), .done_indicator_n_oe(done_oe));

	csc_far_side far_side (
		.vin_ok(vin_ok), .vin_above(vin_above), .vbat(vbat), .cur_lim(cur_lim),
		.temp_mv(temp_mv), .drive(drive), .cmp(cmp_async));

	always #2.5 pclk = ~pclk;

	// ---------------------------------------------------------------
	// Tasks
	// ---------------------------------------------------------------
	task automatic summarize();
		$display("Checks %0d, errors %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		@(posedge pclk);
		psel    <= 1'b1;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd      = prdata;
		err     = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	// Sync, state and drive need a handful of edges; 16 covers one dependent step
	task automatic go(input logic uv, input logic va, input logic [15:0] vb,
		input logic [9:0] lim, input logic [11:0] mv);
		@(posedge pclk);
		vin_ok    <= uv;
		vin_above <= va;
		vbat      <= vb;
		cur_lim   <= lim;
		temp_mv   <= mv;
		repeat (16) @(posedge pclk);
	endtask

	task automatic ex(input logic [2:0] s, input logic [2:0] z, input logic co, input logic dn);
		apb(1'b0, csc_pkg::CSC_ADDR_STATUS, 32'h0000_0000);
		chk(32'(rd[2:0]), 32'(s));
		chk(32'(rd[5:3]), 32'(z));
		chk(32'(chg_oe), 32'(co));
		chk(32'(done_oe), 32'(dn));
		chk(32'(drive.high_side_en), 32'(co));
		chk(32'(drive.reverse_block_gate), 32'(s == 3'h0));
		if (!co) begin
			chk(32'(drive.low_side_en), 32'h0000_0000);
		end
	endtask

	always @(posedge pclk) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			n_fail++;
			summarize();
		end
	end

	// ---------------------------------------------------------------
	// Main sequence
	// ---------------------------------------------------------------
	initial begin
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		ex(3'h0, 3'h2, 1'b0, 1'b0);
		chk(32'({chg_o, done_o}), 32'h0000_0000);
		apb(1'b0, csc_pkg::CSC_ADDR_CTRL, 32'h0000_0000);
		chk(rd, csc_pkg::CSC_CTRL_RESET);
		apb(1'b0, 8'h10, 32'h0000_0000);
		chk({rd[30:0], err}, 32'h0000_0001);
		go(1'b1, 1'b0, 16'h1388, 10'h3e8, 12'h12c);
		ex(3'h0, 3'h2, 1'b0, 1'b0);
		go(1'b1, 1'b1, 16'h1388, 10'h3e8, 12'h12c);
		ex(3'h1, 3'h2, 1'b1, 1'b0);
		chk(32'(drive.current_scale), 32'(csc_pkg::CSC_I_QUARTER));
		apb(1'b0, csc_pkg::CSC_ADDR_FLAGS, 32'h0000_0000);
		chk(rd, 32'(cmp_async));
		for (int k = 0; k < 14; k++) begin
			go(1'b1, 1'b1, tcs[k].vb, 10'h3e8, tcs[k].mv);
			ex(tcs[k].s, tcs[k].z, tcs[k].s != 3'h6, 1'b0);
			if (tcs[k].s != 3'h6) begin
				chk(32'(drive.current_scale), 32'(tcs[k].i));
				chk(32'(drive.regulation_target_voltage), 32'(tcs[k].v));
			end
		end
		go(1'b1, 1'b1, 16'h2710, 10'h1f4, 12'h12c);
		ex(3'h3, 3'h2, 1'b1, 1'b0);
		go(1'b1, 1'b1, 16'h2710, 10'h064, 12'h12c);
		ex(3'h4, 3'h2, 1'b0, 1'b1);
		go(1'b1, 1'b1, 16'h251c, 10'h1f4, 12'h12c);
		ex(3'h3, 3'h2, 1'b1, 1'b0);
		apb(1'b1, csc_pkg::CSC_ADDR_CTRL, 32'h0000_0001);
		go(1'b1, 1'b1, 16'h251c, 10'h064, 12'h12c);
		chk(32'({chg_oe, done_oe}), 32'h0000_0002);
		go(1'b1, 1'b1, 16'h25e4, 10'h064, 12'h12c);
		ex(3'h4, 3'h2, 1'b0, 1'b1);
		chk(32'(rd[13:6]), 32'h0000_0002);
		apb(1'b1, csc_pkg::CSC_ADDR_CTRL, 32'h0000_0002);
		go(1'b1, 1'b1, 16'h2af8, 10'h1f4, 12'h12c);
		apb(1'b0, csc_pkg::CSC_ADDR_STATUS, 32'h0000_0000);
		chk(32'(rd[2:0]), 32'h0000_0005);
		chk(32'(rd[13:6]), 32'h0000_0000);
		chk(32'({drive.high_side_en, drive.low_side_en}), 32'h0000_0000);
		go(1'b1, 1'b1, 16'h26ac, 10'h1f4, 12'h12c);
		ex(3'h3, 3'h2, 1'b1, 1'b0);
		apb(1'b0, csc_pkg::CSC_ADDR_DRIVE, 32'h0000_0000);
		chk(rd, {3'h0, 5'h1c, csc_pkg::CSC_I_FULL, csc_pkg::CSC_V_NOMINAL});
		solar_tracking_mode <= 1'b1;
		repeat (2) @(posedge pclk);
		go(1'b1, 1'b1, 16'h251c, 10'h064, 12'h12c);
		chk(32'({chg_oe, done_oe}), 32'h0000_0002);
		solar_tracking_mode <= 1'b0;
		go(1'b1, 1'b0, 16'h26ac, 10'h1f4, 12'h12c);
		ex(3'h0, 3'h2, 1'b0, 1'b0);
		go(1'b0, 1'b1, 16'h26ac, 10'h1f4, 12'h12c);
		ex(3'h0, 3'h2, 1'b0, 1'b0);
		summarize();
	end
endmodule // test_charge_state_controller
